// ===== rtl/spi_flash_command_decoder.sv
`default_nettype none

module spi_flash_command_decoder (
    // system clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                ce,
    // link pins
    input  wire logic                sck,
    input  wire logic                cs_n,
    input  wire logic [3:0]          io_in,
    // bank register port
    input  wire logic                bank_reg_wr,
    input  wire logic [7:0]          bank_reg_data,
    output logic      [7:0]          bank_reg_value,
    output logic                     extended_address_enable,
    // decoded command
    output logic                     frame_active,
    output logic                     cmd_valid,
    output spi_cmd_pkg::cmd_t        cmd_code,
    output logic                     cmd_nop,
    output logic      [2:0]          addr_lanes,
    output logic                     ddr_mode,
    output logic                     addr_long,
    output logic                     addr_valid,
    output logic      [31:0]         start_addr
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CODE,
        ST_ADDR,
        ST_HOLD
    } state_t;

    typedef struct packed {
        state_t            state;
        logic [1:0]        sel_sync;
        logic [1:0]        code_sync;
        logic [1:0]        a3_sync;
        logic [1:0]        a4_sync;
        logic [7:0]        bank_reg;
        spi_cmd_pkg::cmd_t cmd;
        logic              frame;
        logic              cmd_valid;
        logic              nop;
        logic [2:0]        lanes;
        logic              ddr;
        logic              use4;
        logic              addr_valid;
        logic [31:0]       addr;
    } core_t;

    localparam core_t CORE_RST = '{
        state:    ST_IDLE,
        bank_reg: spi_cmd_pkg::BANK_REG_RST,
        cmd:      spi_cmd_pkg::CMD_NOP,
        default:  '0
    };

    link_if lnk ();

    link_capture u_link (
        .sck   (sck),
        .cs_n  (cs_n),
        .io_in (io_in),
        .lnk   (lnk.capture)
    );

    core_t               s_ff;
    core_t               nxt_s;
    spi_cmd_pkg::attr_t  attr;
    logic                selected;
    logic                addr_ready;
    logic [31:0]         mapped;

    always_comb begin
        nxt_s            = s_ff;
        nxt_s.cmd_valid  = 1'b0;
        nxt_s.addr_valid = 1'b0;
        // selection is synchronised as a level, active high
        nxt_s.sel_sync   = {s_ff.sel_sync[0], ~cs_n};
        nxt_s.code_sync  = {s_ff.code_sync[0], lnk.code_seen};
        nxt_s.a3_sync    = {s_ff.a3_sync[0], lnk.addr3_seen};
        nxt_s.a4_sync    = {s_ff.a4_sync[0], lnk.addr4_seen};
        selected         = s_ff.sel_sync[1];
        // code and addresses stay still while their seen level is high
        attr             = spi_cmd_pkg::decode_code(lnk.code);
        addr_ready       = s_ff.use4 ? s_ff.a4_sync[1] : s_ff.a3_sync[1];
        // top byte from the bank bits only in three-byte mode
        mapped           = s_ff.use4 ? (lnk.addr4 & spi_cmd_pkg::ARRAY_MASK)
                                     : {spi_cmd_pkg::BANK_PAD, s_ff.bank_reg[1:0], lnk.addr3};

        if (bank_reg_wr) begin
            nxt_s.bank_reg = bank_reg_data & spi_cmd_pkg::BANK_REG_MSK;
        end

        case (s_ff.state)
            ST_IDLE: begin
                if (selected) begin
                    nxt_s.state = ST_CODE;
                    nxt_s.frame = 1'b1;
                end
            end
            ST_CODE: begin
                if (!selected) begin
                    nxt_s.state = ST_IDLE;
                    nxt_s.frame = 1'b0;
                end else if (s_ff.code_sync[1]) begin
                    if (!attr.known) begin
                        // previous decode results kept, frame just ridden out
                        nxt_s.nop   = 1'b1;
                        nxt_s.state = ST_HOLD;
                    end else begin
                        nxt_s.nop       = 1'b0;
                        nxt_s.cmd       = attr.cmd;
                        nxt_s.cmd_valid = 1'b1;
                        nxt_s.lanes     = attr.lanes;
                        nxt_s.ddr       = attr.ddr;
                        nxt_s.use4      = attr.force4 | s_ff.bank_reg[spi_cmd_pkg::EXT_ADDR_BIT];
                        // double-rate addresses are not captured here
                        nxt_s.state     = (attr.has_addr && !attr.ddr) ? ST_ADDR : ST_HOLD;
                    end
                end
            end
            ST_ADDR: begin
                if (!selected) begin
                    nxt_s.state = ST_IDLE;
                    nxt_s.frame = 1'b0;
                end else if (addr_ready) begin
                    // sampled once: later bank writes do not move this access
                    nxt_s.addr       = mapped;
                    nxt_s.addr_valid = 1'b1;
                    nxt_s.state      = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!selected) begin
                    nxt_s.state = ST_IDLE;
                    nxt_s.frame = 1'b0;
                end
            end
            default: begin
                nxt_s.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_ff <= CORE_RST;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign bank_reg_value          = s_ff.bank_reg;
    assign extended_address_enable = s_ff.bank_reg[spi_cmd_pkg::EXT_ADDR_BIT];
    assign frame_active            = s_ff.frame;
    assign cmd_valid               = s_ff.cmd_valid;
    assign cmd_code                = s_ff.cmd;
    assign cmd_nop                 = s_ff.nop;
    assign addr_lanes              = s_ff.lanes;
    assign ddr_mode                = s_ff.ddr;
    assign addr_long               = s_ff.use4;
    assign addr_valid              = s_ff.addr_valid;
    assign start_addr              = s_ff.addr;
endmodule

`default_nettype wire

// ===== common/spi_cmd_pkg.sv
`default_nettype none

package spi_cmd_pkg;
    localparam logic [7:0] OP_ID_READ      = 8'h9f;
    localparam logic [7:0] OP_SIGNATURE    = 8'h90;
    localparam logic [7:0] OP_PARAM_TABLE  = 8'h5a;
    localparam logic [7:0] OP_STAT_CFG_WR  = 8'h01;
    localparam logic [7:0] OP_STAT_CLEAR   = 8'h30;
    localparam logic [7:0] OP_CORR_READ    = 8'h18;
    localparam logic [7:0] OP_PAT_READ     = 8'h41;
    localparam logic [7:0] OP_NV_PAT_PROG  = 8'h43;
    localparam logic [7:0] OP_VOL_PAT_WR   = 8'h4a;
    localparam logic [7:0] OP_READ         = 8'h03;
    localparam logic [7:0] OP_FAST_READ    = 8'h0b;
    localparam logic [7:0] OP_DDR_FAST     = 8'h0d;
    localparam logic [7:0] OP_TWO_OUT      = 8'h3b;
    localparam logic [7:0] OP_FOUR_OUT     = 8'h6b;
    localparam logic [7:0] OP_TWO_IO       = 8'hbb;
    localparam logic [7:0] OP_DDR_FOUR_IO  = 8'hed;
    localparam logic [7:0] OP_FOUR_IO_LONG = 8'hec;
    localparam logic [7:0] OP_PP_LONG      = 8'h12;
    localparam logic [7:0] OP_FOUR_PP      = 8'h32;
    localparam logic [7:0] OP_FOUR_PP_ALT  = 8'h38;
    localparam logic [7:0] OP_FOUR_PP_LONG = 8'h34;

    localparam logic [3:0]  INSTR_BITS   = 4'h8;
    localparam logic [5:0]  ADDR3_BITS   = 6'h18;
    localparam logic [5:0]  ADDR4_BITS   = 6'h20;
    localparam logic [2:0]  LANES_1      = 3'h1;
    localparam logic [2:0]  LANES_2      = 3'h2;
    localparam logic [2:0]  LANES_4      = 3'h4;
    localparam int          EXT_ADDR_BIT = 7;
    localparam logic [7:0]  BANK_REG_RST = 8'h00;
    localparam logic [7:0]  BANK_REG_MSK = 8'h83;
    localparam logic [31:0] ARRAY_MASK   = 32'h03ff_ffff;
    localparam logic [5:0]  BANK_PAD     = 6'h00;

    typedef enum logic [4:0] {
        CMD_NOP,
        CMD_ID_READ,
        CMD_SIGNATURE,
        CMD_PARAM_TABLE,
        CMD_STAT_CFG_WR,
        CMD_STAT_CLEAR,
        CMD_CORR_READ,
        CMD_PAT_READ,
        CMD_NV_PAT_PROG,
        CMD_VOL_PAT_WR,
        CMD_READ,
        CMD_FAST_READ,
        CMD_DDR_FAST,
        CMD_TWO_OUT,
        CMD_FOUR_OUT,
        CMD_TWO_IO,
        CMD_DDR_FOUR_IO,
        CMD_FOUR_IO_LONG,
        CMD_PP_LONG,
        CMD_FOUR_PP,
        CMD_FOUR_PP_LONG
    } cmd_t;

    typedef struct packed {
        cmd_t       cmd;
        logic       known;
        logic       has_addr;
        logic       force4;
        logic [2:0] lanes;
        logic       ddr;
    } attr_t;

    function automatic attr_t mk(input cmd_t c, input logic ad, input logic f4,
                                 input logic [2:0] ln, input logic dr);
        mk = '{cmd: c, known: 1'b1, has_addr: ad, force4: f4, lanes: ln, ddr: dr};
    endfunction

    function automatic attr_t decode_code(input logic [7:0] code);
        attr_t a;
        a = '{cmd: CMD_NOP, known: 1'b0, has_addr: 1'b0, force4: 1'b0, lanes: LANES_1, ddr: 1'b0};
        case (code)
            OP_ID_READ:      a = mk(CMD_ID_READ, 1'b0, 1'b0, LANES_1, 1'b0);
            OP_SIGNATURE:    a = mk(CMD_SIGNATURE, 1'b0, 1'b0, LANES_1, 1'b0);
            OP_PARAM_TABLE:  a = mk(CMD_PARAM_TABLE, 1'b0, 1'b0, LANES_1, 1'b0);
            OP_STAT_CFG_WR:  a = mk(CMD_STAT_CFG_WR, 1'b0, 1'b0, LANES_1, 1'b0);
            OP_STAT_CLEAR:   a = mk(CMD_STAT_CLEAR, 1'b0, 1'b0, LANES_1, 1'b0);
            OP_CORR_READ:    a = mk(CMD_CORR_READ, 1'b1, 1'b1, LANES_1, 1'b0);
            OP_PAT_READ:     a = mk(CMD_PAT_READ, 1'b0, 1'b0, LANES_1, 1'b0);
            OP_NV_PAT_PROG:  a = mk(CMD_NV_PAT_PROG, 1'b0, 1'b0, LANES_1, 1'b0);
            OP_VOL_PAT_WR:   a = mk(CMD_VOL_PAT_WR, 1'b0, 1'b0, LANES_1, 1'b0);
            OP_READ:         a = mk(CMD_READ, 1'b1, 1'b0, LANES_1, 1'b0);
            OP_FAST_READ:    a = mk(CMD_FAST_READ, 1'b1, 1'b0, LANES_1, 1'b0);
            OP_DDR_FAST:     a = mk(CMD_DDR_FAST, 1'b1, 1'b0, LANES_1, 1'b1);
            OP_TWO_OUT:      a = mk(CMD_TWO_OUT, 1'b1, 1'b0, LANES_1, 1'b0);
            OP_FOUR_OUT:     a = mk(CMD_FOUR_OUT, 1'b1, 1'b0, LANES_1, 1'b0);
            OP_TWO_IO:       a = mk(CMD_TWO_IO, 1'b1, 1'b0, LANES_2, 1'b0);
            OP_DDR_FOUR_IO:  a = mk(CMD_DDR_FOUR_IO, 1'b1, 1'b0, LANES_4, 1'b1);
            OP_FOUR_IO_LONG: a = mk(CMD_FOUR_IO_LONG, 1'b1, 1'b1, LANES_4, 1'b0);
            OP_PP_LONG:      a = mk(CMD_PP_LONG, 1'b1, 1'b1, LANES_1, 1'b0);
            OP_FOUR_PP:      a = mk(CMD_FOUR_PP, 1'b1, 1'b0, LANES_1, 1'b0);
            OP_FOUR_PP_ALT:  a = mk(CMD_FOUR_PP, 1'b1, 1'b0, LANES_1, 1'b0);
            OP_FOUR_PP_LONG: a = mk(CMD_FOUR_PP_LONG, 1'b1, 1'b1, LANES_1, 1'b0);
            default:         a.known = 1'b0;
        endcase
        return a;
    endfunction
endpackage

`default_nettype wire

// ===== common/link_if.sv
`default_nettype none

interface link_if;
    logic [7:0]  code;
    logic        code_seen;
    logic [23:0] addr3;
    logic        addr3_seen;
    logic [31:0] addr4;
    logic        addr4_seen;

    modport capture (output code, code_seen, addr3, addr3_seen, addr4, addr4_seen);
    modport core    (input  code, code_seen, addr3, addr3_seen, addr4, addr4_seen);
endinterface

`default_nettype wire

// ===== rtl/link_capture.sv
`default_nettype none

module link_capture (
    // link pins
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic [3:0] io_in,
    // captured fields
    link_if.capture         lnk
);
    typedef struct packed {
        logic [3:0]  bit_cnt;
        logic [5:0]  addr_bits;
        logic [31:0] shift;
        logic [7:0]  code;
        logic        code_seen;
        logic [23:0] addr3;
        logic        addr3_seen;
        logic [31:0] addr4;
        logic        addr4_seen;
    } cap_t;

    cap_t                  s_ff;
    cap_t                  nxt_s;
    spi_cmd_pkg::attr_t    attr;
    logic [31:0]           shifted;
    logic [5:0]            bits_next;

    always_comb begin
        nxt_s     = s_ff;
        attr      = spi_cmd_pkg::decode_code(s_ff.code);
        shifted   = {s_ff.shift[30:0], io_in[0]};
        bits_next = s_ff.addr_bits + {3'h0, attr.lanes};
        if (s_ff.bit_cnt < spi_cmd_pkg::INSTR_BITS) begin
            // msb first on io0 only
            nxt_s.shift   = shifted;
            nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
            if (s_ff.bit_cnt == spi_cmd_pkg::INSTR_BITS - 4'h1) begin
                nxt_s.code      = shifted[7:0];
                nxt_s.code_seen = 1'b1;
                nxt_s.shift     = '0;
            end
        end else if (attr.has_addr && !attr.ddr && s_ff.addr_bits < spi_cmd_pkg::ADDR4_BITS) begin
            case (attr.lanes)
                spi_cmd_pkg::LANES_2: shifted = {s_ff.shift[29:0], io_in[1:0]};
                spi_cmd_pkg::LANES_4: shifted = {s_ff.shift[27:0], io_in[3:0]};
                default:              shifted = {s_ff.shift[30:0], io_in[0]};
            endcase
            nxt_s.shift     = shifted;
            nxt_s.addr_bits = bits_next;
            if (bits_next == spi_cmd_pkg::ADDR3_BITS) begin
                nxt_s.addr3      = shifted[23:0];
                nxt_s.addr3_seen = 1'b1;
            end
            if (bits_next == spi_cmd_pkg::ADDR4_BITS) begin
                nxt_s.addr4      = shifted;
                nxt_s.addr4_seen = 1'b1;
            end
        end
    end

    // frame end clears everything; sck stands still between frames
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign lnk.code       = s_ff.code;
    assign lnk.code_seen  = s_ff.code_seen;
    assign lnk.addr3      = s_ff.addr3;
    assign lnk.addr3_seen = s_ff.addr3_seen;
    assign lnk.addr4      = s_ff.addr4;
    assign lnk.addr4_seen = s_ff.addr4_seen;
endmodule

`default_nettype wire

// ===== test/spi_flash_command_decoder_assertions.sv
`default_nettype none

module decoder_checker (
    // clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // watched inputs
    input wire logic              ce,
    input wire logic              cs_n,
    input wire logic              bank_reg_wr,
    input wire logic [7:0]        bank_reg_data,
    // watched outputs
    input wire logic [7:0]        bank_reg_value,
    input wire logic              extended_address_enable,
    input wire logic              frame_active,
    input wire logic              cmd_valid,
    input wire spi_cmd_pkg::cmd_t cmd_code,
    input wire logic              cmd_nop,
    input wire logic              ddr_mode,
    input wire logic              addr_long,
    input wire logic              addr_valid,
    input wire logic [31:0]       start_addr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_bank_load; ce && bank_reg_wr |=> bank_reg_value == ($past(bank_reg_data) & 8'h83); endproperty
    a_bank_load: assert property (p_bank_load) else $error("bank register load wrong");
    property p_bank_hold; !(ce && bank_reg_wr) |=> $stable(bank_reg_value); endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank register moved");
    property p_ext_long; cmd_valid && extended_address_enable |=> addr_long; endproperty
    a_ext_long: assert property (p_ext_long) else $error("extended mode not long");
    property p_cmd_pulse; cmd_valid |=> !cmd_valid; endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
    property p_known; cmd_valid |=> !cmd_nop && cmd_code != spi_cmd_pkg::CMD_NOP; endproperty
    a_known: assert property (p_known) else $error("known code marked idle");
    property p_nop_quiet; $rose(cmd_nop) |-> !cmd_valid && !addr_valid && $stable(cmd_code); endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("unknown code acted");
    property p_addr_order; addr_valid |-> !cmd_valid && !ddr_mode; endproperty
    a_addr_order: assert property (p_addr_order) else $error("address pulse misplaced");
    property p_long_range; addr_valid && addr_long |-> start_addr[31:26] == 6'h00; endproperty
    a_long_range: assert property (p_long_range) else $error("long address out of array");
    property p_short_bank;
        addr_valid && !addr_long |-> start_addr[31:24] == {6'h00, bank_reg_value[1:0]};
    endproperty
    a_short_bank: assert property (p_short_bank) else $error("bank byte wrong");
    property p_force4;
        cmd_valid ##1 (cmd_code inside {spi_cmd_pkg::CMD_CORR_READ, spi_cmd_pkg::CMD_FOUR_IO_LONG,
                                        spi_cmd_pkg::CMD_PP_LONG, spi_cmd_pkg::CMD_FOUR_PP_LONG}) |-> addr_long;
    endproperty
    a_force4: assert property (p_force4) else $error("forced long address missing");
    property p_frame_end; cs_n [*6] |-> !frame_active; endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame did not end");
endmodule

bind spi_flash_command_decoder decoder_checker chk (.clk, .reset_n, .ce, .cs_n, .bank_reg_wr, .bank_reg_data,
    .bank_reg_value, .extended_address_enable, .frame_active, .cmd_valid, .cmd_code, .cmd_nop, .ddr_mode,
    .addr_long, .addr_valid, .start_addr);

`default_nettype wire

// ===== test/spi_host_model.sv
`default_nettype none

module spi_host_model (
    // link pins
    output logic       sck,
    output logic       cs_n,
    output logic [3:0] io_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // 31.25 MHz link clock, under every per-code ceiling
    localparam int HALF = 16;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h5;
    end

    // unused lanes driven high so a lane slip shows
    task automatic shift_out(input logic [3:0] v, input logic [3:0] m);
        io_in = (v & m) | ~m;
        #(HALF);
        sck = 1'b1;
        #(HALF);
        sck = 1'b0;
    endtask

    task automatic frame(input logic [7:0] op, input logic [31:0] adr, input int nbits, input int lanes);
        logic [3:0] msk;
        int         i;
        msk = (lanes == 4) ? 4'hf : (lanes == 2) ? 4'h3 : 4'h1;
        cs_n = 1'b0;
        #(HALF);
        for (i = 7; i >= 0; i--) shift_out({3'h0, op[i]}, 4'h1);
        for (i = nbits - lanes; i >= 0; i -= lanes) shift_out(4'(adr >> i), msk);
        // select held past the decoder's synchroniser delay
        #(HALF * 12);
        cs_n = 1'b1;
        io_in = ~io_in;
        #(HALF * 13);
    endtask
endmodule

`default_nettype wire

// ===== test/spi_flash_command_decoder_test.sv
`default_nettype none

module spi_flash_command_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]        op;
        spi_cmd_pkg::cmd_t c;
        logic [2:0]        ln;
        logic [2:0]        fl;
    } row_t;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              ce = 1'b1;
    logic              bank_reg_wr = 1'b0;
    logic [7:0]        bank_reg_data = 8'h00;
    wire logic         sck;
    wire logic         cs_n;
    wire logic [3:0]   io_in;
    logic [7:0]        bank_reg_value;
    logic              ext_en;
    logic              frame_active;
    logic              cmd_valid;
    spi_cmd_pkg::cmd_t cmd_code;
    logic              cmd_nop;
    logic [2:0]        addr_lanes;
    logic              ddr_mode;
    logic              addr_long;
    logic              addr_valid;
    logic [31:0]       start_addr;
    int                err_total = 0;
    int                num_checks = 0;
    int                n_cmd = 0;
    int                n_addr = 0;
    int                n_act = 0;
    // fl is {double rate, address pulse expected, forced long}
    row_t rows [21] = '{
        '{8'h9f, spi_cmd_pkg::CMD_ID_READ, 3'h1, 3'h0},
        '{8'h90, spi_cmd_pkg::CMD_SIGNATURE, 3'h1, 3'h0},
        '{8'h5a, spi_cmd_pkg::CMD_PARAM_TABLE, 3'h1, 3'h0},
        '{8'h01, spi_cmd_pkg::CMD_STAT_CFG_WR, 3'h1, 3'h0},
        '{8'h30, spi_cmd_pkg::CMD_STAT_CLEAR, 3'h1, 3'h0},
        '{8'h18, spi_cmd_pkg::CMD_CORR_READ, 3'h1, 3'h3},
        '{8'h41, spi_cmd_pkg::CMD_PAT_READ, 3'h1, 3'h0},
        '{8'h43, spi_cmd_pkg::CMD_NV_PAT_PROG, 3'h1, 3'h0},
        '{8'h4a, spi_cmd_pkg::CMD_VOL_PAT_WR, 3'h1, 3'h0},
        '{8'h03, spi_cmd_pkg::CMD_READ, 3'h1, 3'h2},
        '{8'h0b, spi_cmd_pkg::CMD_FAST_READ, 3'h1, 3'h2},
        '{8'h0d, spi_cmd_pkg::CMD_DDR_FAST, 3'h1, 3'h4},
        '{8'h3b, spi_cmd_pkg::CMD_TWO_OUT, 3'h1, 3'h2},
        '{8'h6b, spi_cmd_pkg::CMD_FOUR_OUT, 3'h1, 3'h2},
        '{8'hbb, spi_cmd_pkg::CMD_TWO_IO, 3'h2, 3'h2},
        '{8'hed, spi_cmd_pkg::CMD_DDR_FOUR_IO, 3'h4, 3'h4},
        '{8'hec, spi_cmd_pkg::CMD_FOUR_IO_LONG, 3'h4, 3'h3},
        '{8'h12, spi_cmd_pkg::CMD_PP_LONG, 3'h1, 3'h3},
        '{8'h32, spi_cmd_pkg::CMD_FOUR_PP, 3'h1, 3'h2},
        '{8'h38, spi_cmd_pkg::CMD_FOUR_PP, 3'h1, 3'h2},
        '{8'h34, spi_cmd_pkg::CMD_FOUR_PP_LONG, 3'h1, 3'h3}
    };

    spi_flash_command_decoder dut (.clk(clk), .reset_n(reset_n), .ce(ce), .sck(sck), .cs_n(cs_n),
        .io_in(io_in), .bank_reg_wr(bank_reg_wr), .bank_reg_data(bank_reg_data),
        .bank_reg_value(bank_reg_value), .extended_address_enable(ext_en), .frame_active(frame_active),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_nop(cmd_nop), .addr_lanes(addr_lanes),
        .ddr_mode(ddr_mode), .addr_long(addr_long), .addr_valid(addr_valid), .start_addr(start_addr));
    spi_host_model host (.sck(sck), .cs_n(cs_n), .io_in(io_in));

    always #25 clk = ~clk;
    // pulses last one cycle, so count them as they pass
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) n_cmd++;
        if (addr_valid === 1'b1) n_addr++;
        if (frame_active === 1'b1) n_act++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end
        else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic bank_write(input logic [7:0] d);
        @(posedge clk);
        #2;
        bank_reg_wr = 1'b1;
        bank_reg_data = d;
        @(posedge clk);
        #2;
        bank_reg_wr = 1'b0;
    endtask

    task automatic frame(input logic [7:0] op, input logic [31:0] adr, input int nb, input int ln);
        @(posedge clk);
        #2;
        n_cmd = 0;
        n_addr = 0;
        n_act = 0;
        host.frame(op, adr, nb, ln);
    endtask

    task automatic t_reset;
        check(bank_reg_value, 8'h00);
        check(ext_en, 1'b0);
        check(cmd_code, spi_cmd_pkg::CMD_NOP);
        check(frame_active, 1'b0);
    endtask

    task automatic t_banks;
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            b = 8'(i);
            bank_write(b | 8'h7c);
            check(bank_reg_value, b);
            frame(8'h03, 32'h00123456, 24, 1);
            check(start_addr, {6'h00, b[1:0], 24'h123456});
            check(addr_long, 1'b0);
        end
        @(posedge clk);
        #2;
        ce = 1'b0;
        bank_write(8'h80);
        ce = 1'b1;
        check(bank_reg_value, 8'h03);
    endtask

    task automatic t_ext;
        bank_write(8'h82);
        check(ext_en, 1'b1);
        frame(8'h0b, 32'hfedcba98, 32, 1);
        check(addr_long, 1'b1);
        check(start_addr, 32'h02dcba98);
        // mid-run hardware reset must drop back to three-byte addressing
        @(posedge clk);
        #2;
        reset_n = 1'b0;
        @(posedge clk);
        #2;
        reset_n = 1'b1;
        check(ext_en, 1'b0);
        check(bank_reg_value, 8'h00);
    endtask

    task automatic t_table;
        row_t r;
        bank_write(8'h01);
        foreach (rows[k]) begin
            r = rows[k];
            frame(r.op, 32'hfedcba98, r.fl[0] ? 32 : 24, int'(r.ln));
            check(n_cmd, 1);
            check(n_act > 0, 1'b1);
            check(frame_active, 1'b0);
            check(cmd_code, r.c);
            check(addr_lanes, r.ln);
            check(ddr_mode, r.fl[2]);
            check(addr_long, r.fl[0]);
            check(n_addr, r.fl[1]);
            if (r.fl[1]) check(start_addr, r.fl[0] ? 32'h02dcba98 : 32'h01dcba98);
        end
    endtask

    task automatic t_unknown;
        frame(8'h0b, 32'h00123456, 24, 1);
        frame(8'hab, 32'h00123456, 24, 1);
        check(n_cmd, 0);
        check(n_addr, 0);
        check(cmd_nop, 1'b1);
        check(cmd_code, spi_cmd_pkg::CMD_FAST_READ);
        frame(8'h03, 32'h00000000, 8, 1);
        check(cmd_nop, 1'b0);
        check(n_addr, 0);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #2;
        reset_n = 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_banks;
        t_ext;
        t_table;
        t_unknown;
        stop_test;
    end

    initial begin
        #200000;
        err_total++;
        stop_test;
    end
endmodule

`default_nettype wire
